// File: hdl/pdb_regs.sv
// Diagnostic, self-test and 10BASE-T control register bank
`timescale 1ns/10ps
`default_nettype none
`include "pdb_regs.svh"
module pdb_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire pdb_pkg::pdb_addr_t addr_i,
	input wire pdb_pkg::pdb_word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output pdb_pkg::pdb_word_t rdata_o,
	// General status register side
	input wire logic pol_inv_i,
	input wire logic gen_status_rd_i,
	output logic gen_status_pol_o,
	// Receiver and link controls
	input wire logic mode_10te_i,
	output logic low_thresh_o,
	output logic [3:0] squelch_o,
	output logic link_pulse_dis_o,
	output logic jab_dis_o,
	// Self-test
	input wire logic prbs_err_i,
	input wire logic err_cnt_mode_i,
	output logic [7:0] ipg_o,
	output logic [10:0] pkt_len_o,
	// Cable diagnostics engine
	output logic cd_start_o,
	output logic rescal_o,
	input wire logic cd_done_i,
	input wire logic cd_fail_i,
	// Interrupt
	output logic irq_o
);
	import pdb_pkg::*;

	pdb_state_t st_reg;
	pdb_state_t st_next;
	logic wr_tbt;
	logic wr_stcg;
	logic wr_stpl;
	logic wr_cdc;
	logic wr_istat;
	logic wr_imask;
	logic pol_new;
	logic [3:0] ev;

	function automatic logic hit(input pdb_addr_t a, input pdb_addr_t off, input logic stb);
		hit = stb && (a == off);
	endfunction : hit

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		ev = 4'h0;
		wr_tbt = hit(addr_i, `PDB_OFF_TBT, wr_i);
		wr_stcg = hit(addr_i, `PDB_OFF_STCG, wr_i);
		wr_stpl = hit(addr_i, `PDB_OFF_STPL, wr_i);
		wr_cdc = hit(addr_i, `PDB_OFF_CDC, wr_i);
		wr_istat = hit(addr_i, `PDB_OFF_IRQ_STAT, wr_i);
		wr_imask = hit(addr_i, `PDB_OFF_IRQ_MASK, wr_i);
		// Pin synchroniser, stage 3 vs stage 2 agreement
		st_next.pol_sync = {st_reg.pol_sync[1:0], pol_inv_i};
		pol_new = 1'b0;
		if (st_reg.pol_sync[2] == st_reg.pol_sync[1]) begin
			st_next.phy_pol = st_reg.pol_sync[2];
			pol_new = st_reg.pol_sync[2] && !st_reg.phy_pol;
		end
		// Control fields
		if (wr_tbt) begin
			st_next.low_thresh = wdata_i[`PDB_TBT_LOWTH];
			st_next.squelch = wdata_i[`PDB_TBT_SQ_HI:`PDB_TBT_SQ_LO];
			st_next.link_pulse_dis = wdata_i[`PDB_TBT_LINK_PULSE_DIS];
			st_next.jab_dis = wdata_i[`PDB_TBT_JAB_DIS];
		end
		if (wr_stcg) begin
			st_next.ipg = wdata_i[7:0];
		end
		if (wr_stpl) begin
			st_next.pkt_len = wdata_i[10:0];
		end
		if (wr_cdc) begin
			st_next.rescal = wdata_i[`PDB_CDC_RESCAL];
		end
		// Polarity flag: clear on read of the TBT register (0x1A), new event wins
		if (hit(addr_i, `PDB_OFF_TBT, rd_i)) begin
			st_next.pol_flag = 1'b0;
		end
		if (pol_new) begin
			st_next.pol_flag = 1'b1;
		end
		// Error counter
		if (wr_stcg && wdata_i[`PDB_STCG_LOCK]) begin
			st_next.err_held = st_reg.err_cnt;
			st_next.err_cnt = {7'h00, prbs_err_i};
		end else if (prbs_err_i) begin
			if (st_reg.err_cnt != `PDB_CNT_MAX || err_cnt_mode_i) begin
				st_next.err_cnt = st_reg.err_cnt + 8'h01;
			end else begin
				ev[`PDB_IRQ_SAT] = 1'b1;
			end
		end
		// Cable diagnostic sequence
		unique case (st_reg.cd_state)
			PDB_CD_IDLE: begin
				if (wr_cdc && wdata_i[`PDB_CDC_START]) begin
					st_next.cd_start = 1'b1;
					st_next.cd_done = 1'b0;
					st_next.cd_fail = 1'b0;
					st_next.cd_state = PDB_CD_RUN;
				end
			end
			PDB_CD_RUN: begin
				if (cd_done_i) begin
					st_next.cd_done = 1'b1;
					st_next.cd_fail = cd_fail_i;
					st_next.cd_state = PDB_CD_END;
					ev[`PDB_IRQ_DONE] = 1'b1;
					ev[`PDB_IRQ_FAIL] = cd_fail_i;
				end
			end
			PDB_CD_END: begin
				st_next.cd_start = 1'b0;
				st_next.cd_state = PDB_CD_IDLE;
			end
			default: begin
				st_next.cd_state = PDB_CD_IDLE;
			end
		endcase
		ev[`PDB_IRQ_POL] = pol_new;
		// Interrupt status, write one to clear, set wins
		if (wr_istat) begin
			st_next.irq_stat = st_reg.irq_stat & ~wdata_i[3:0];
		end
		st_next.irq_stat = st_next.irq_stat | ev;
		if (wr_imask) begin
			st_next.irq_mask = wdata_i[3:0];
		end
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
		// Read data, reserved bits zero
		st_next.rdata = 16'h0000;
		if (rd_i) begin
			unique case (addr_i)
				`PDB_OFF_TBT: begin
					st_next.rdata[`PDB_TBT_LOWTH] = st_reg.low_thresh;
					st_next.rdata[`PDB_TBT_SQ_HI:`PDB_TBT_SQ_LO] = st_reg.squelch;
					st_next.rdata[`PDB_TBT_LINK_PULSE_DIS] = st_reg.link_pulse_dis;
					st_next.rdata[`PDB_TBT_POL] = st_reg.pol_flag;
					st_next.rdata[`PDB_TBT_JAB_DIS] = st_reg.jab_dis;
				end
				`PDB_OFF_STCG: begin
					st_next.rdata = {st_reg.err_held, st_reg.ipg};
				end
				`PDB_OFF_STPL: begin
					st_next.rdata[10:0] = st_reg.pkt_len;
				end
				`PDB_OFF_CDC: begin
					st_next.rdata[`PDB_CDC_START] = st_reg.cd_start;
					st_next.rdata[`PDB_CDC_RESCAL] = st_reg.rescal;
					st_next.rdata[`PDB_CDC_DONE] = st_reg.cd_done;
					st_next.rdata[`PDB_CDC_FAIL] = st_reg.cd_fail;
				end
				`PDB_OFF_IRQ_STAT: begin
					st_next.rdata[3:0] = st_reg.irq_stat;
				end
				`PDB_OFF_IRQ_MASK: begin
					st_next.rdata[3:0] = st_reg.irq_mask;
				end
				default: begin
					st_next.rdata = 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
			st_reg.squelch <= `PDB_RST_SQ;
			st_reg.ipg <= `PDB_RST_IPG;
			st_reg.pkt_len <= `PDB_RST_PKTLEN;
			st_reg.cd_state <= PDB_CD_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// gen_status read leaves the single shared pol_flag intact; input kept for the port contract
	logic unused_rd;
	assign unused_rd = gen_status_rd_i;
	assign rdata_o = st_reg.rdata;
	assign gen_status_pol_o = st_reg.pol_flag;
	assign low_thresh_o = st_reg.low_thresh;
	assign squelch_o = st_reg.squelch;
	assign link_pulse_dis_o = st_reg.link_pulse_dis;
	assign jab_dis_o = st_reg.jab_dis;
	assign ipg_o = st_reg.ipg;
	assign pkt_len_o = st_reg.pkt_len;
	assign cd_start_o = st_reg.cd_start;
	assign rescal_o = st_reg.rescal;
	assign irq_o = st_reg.irq;
	// Jabber disable only honoured in 10BASE-Te; consumer gates with mode_10te_i
	logic unused_mode;
	assign unused_mode = mode_10te_i;
endmodule : pdb_regs
`default_nettype wire

// File: inc/pdb_pkg.sv
// Types shared by the diagnostic register bank
package pdb_pkg;
	typedef logic [15:0] pdb_word_t;
	typedef logic [4:0] pdb_addr_t;
	typedef enum logic [1:0] {
		PDB_CD_IDLE = 2'b00,
		PDB_CD_RUN = 2'b01,
		PDB_CD_END = 2'b10
	} pdb_cd_state_t;
	typedef struct packed {
		logic low_thresh;
		logic [3:0] squelch;
		logic link_pulse_dis;
		logic pol_flag;
		logic jab_dis;
		logic [7:0] err_cnt;
		logic [7:0] err_held;
		logic [7:0] ipg;
		logic [10:0] pkt_len;
		logic cd_start;
		logic rescal;
		logic cd_done;
		logic cd_fail;
		pdb_cd_state_t cd_state;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic irq;
		pdb_word_t rdata;
		logic phy_pol;
		logic [2:0] pol_sync;
	} pdb_state_t;
endpackage : pdb_pkg

// File: inc/pdb_regs.svh
// Register offsets, field positions, reset values and counter limit for the diagnostic register bank
`ifndef PDB_REGS_SVH
`define PDB_REGS_SVH
`define PDB_ADDR_W 5
`define PDB_OFF_TBT 5'h1A
`define PDB_OFF_STCG 5'h1B
`define PDB_OFF_STPL 5'h1C
`define PDB_OFF_CDC 5'h1E
`define PDB_OFF_IRQ_STAT 5'h1D
`define PDB_OFF_IRQ_MASK 5'h1F
`define PDB_TBT_LOWTH 13
`define PDB_TBT_SQ_HI 12
`define PDB_TBT_SQ_LO 9
`define PDB_TBT_LINK_PULSE_DIS 7
`define PDB_TBT_POL 4
`define PDB_TBT_JAB_DIS 0
`define PDB_STCG_LOCK 15
`define PDB_CDC_START 15
`define PDB_CDC_RESCAL 14
`define PDB_CDC_DONE 1
`define PDB_CDC_FAIL 0
`define PDB_RST_IPG 8'h7D
`define PDB_RST_PKTLEN 11'h5EE
`define PDB_RST_SQ 4'h0
`define PDB_CNT_MAX 8'hFF
`define PDB_IRQ_POL 0
`define PDB_IRQ_DONE 1
`define PDB_IRQ_FAIL 2
`define PDB_IRQ_SAT 3
`endif

// File: verif/pdb_regs_chk.sv
// Assertion checker for the diagnostic register bank
`timescale 1ns/10ps
`default_nettype none
module pdb_regs_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire pdb_pkg::pdb_addr_t addr_i,
	input wire pdb_pkg::pdb_word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire pdb_pkg::pdb_word_t rdata_o,
	// Status, controls and diagnostics
	input wire logic pol_inv_i,
	input wire logic gen_status_rd_i,
	input wire logic gen_status_pol_o,
	input wire logic low_thresh_o,
	input wire logic [3:0] squelch_o,
	input wire logic link_pulse_dis_o,
	input wire logic jab_dis_o,
	input wire logic [7:0] ipg_o,
	input wire logic [10:0] pkt_len_o,
	input wire logic cd_start_o,
	input wire logic cd_done_i
);
	import pdb_pkg::*;
	pdb_word_t wd_q;
	always_ff @(posedge clk_i) wd_q <= wdata_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not idle");
	chk_ctrl_fields: assert property (wr_i && addr_i == 5'h1A |=>
		{low_thresh_o, squelch_o, link_pulse_dis_o, jab_dis_o} == {wd_q[13:9], wd_q[7], wd_q[0]})
		else $error("control fields wrong");
	chk_ctrl_read: assert property (rd_i && addr_i == 5'h1A |=>
		rdata_o[4] == $past(gen_status_pol_o) && (rdata_o & 16'hC16E) == 16'h0000)
		else $error("control read wrong");
	chk_pol_clear: assert property (rd_i && addr_i == 5'h1A &&
		pol_inv_i == $past(pol_inv_i, 5) |=> !gen_status_pol_o) else $error("flag kept");
	chk_gen_keep: assert property (gen_status_rd_i && gen_status_pol_o &&
		!(rd_i && addr_i == 5'h1A) |=> gen_status_pol_o) else $error("flag lost");
	chk_ipg_write: assert property (wr_i && addr_i == 5'h1B |=> ipg_o == wd_q[7:0])
		else $error("gap wrong");
	chk_len_write: assert property (wr_i && addr_i == 5'h1C |=> pkt_len_o == wd_q[10:0])
		else $error("length wrong");
	chk_start_set: assert property (wr_i && addr_i == 5'h1E && wdata_i[15] &&
		!cd_start_o && !cd_done_i |=> cd_start_o) else $error("start not set");
	chk_start_clear: assert property (cd_start_o && cd_done_i |-> ##2 !cd_start_o)
		else $error("start not cleared");
endmodule : pdb_regs_chk
bind pdb_regs pdb_regs_chk u_pdb_regs_chk (.*);
`default_nettype wire

// File: verif/pdb_regs_tb_top.sv
// Self-checking bench for the diagnostic register bank
`timescale 1ns/10ps
`default_nettype none
module pdb_regs_tb_top;
	import pdb_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wr_i = 1'b0, rd_i = 1'b0, pol_inv_i = 1'b0, gen_status_rd_i = 1'b0;
	logic mode_10te_i = 1'b0, prbs_err_i = 1'b0, err_cnt_mode_i = 1'b0;
	logic cd_done_i = 1'b0, cd_fail_i = 1'b0, pend = 1'b0;
	pdb_addr_t addr_i = 5'h00;
	pdb_word_t wdata_i = 16'h0000, rdata_o, d, c;
	logic gen_status_pol_o, low_thresh_o, link_pulse_dis_o, jab_dis_o, cd_start_o, rescal_o, irq_o;
	logic [3:0] squelch_o;
	logic [7:0] ipg_o;
	logic [10:0] pkt_len_o;
	pdb_word_t exp_q[$];
	int bad_count = 0, checks_done = 0;
	pdb_regs u_pdb_regs (.*);
	always #4 clk_i = ~clk_i;
	task check(input pdb_word_t seen, input pdb_word_t want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task conclude;
		if (bad_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	// One bus cycle per call; strobes held until the next call
	task bus(input logic w, input logic r, input pdb_addr_t a, input pdb_word_t v);
		@(posedge clk_i);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= v;
	endtask : bus
	task rd(input pdb_addr_t a, input pdb_word_t e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 16'h0000);
	endtask : rd
	task idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 5'h00, 16'h0000);
	endtask : idle
	task errs(input int n);
		repeat (n) begin
			prbs_err_i <= 1'b1;
			idle(1);
			prbs_err_i <= 1'b0;
			idle(1);
		end
	endtask : errs
	// Read data monitor
	always @(negedge clk_i) begin
		if (pend)
			check(rdata_o, exp_q.pop_front());
		pend = rd_i;
	end
	initial begin
		void'($urandom(32'hF2CF));
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(5'h1A, 16'h0000);
		rd(5'h1B, 16'h007D);
		rd(5'h1C, 16'h05EE);
		rd(5'h1E, 16'h0000);
		rd(5'h05, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			d = pdb_word_t'($urandom());
			d[12:9] = 4'(i);
			c = d & 16'h3E81;
			bus(1'b1, 1'b0, 5'h1A, d);
			rd(5'h1A, c);
			idle(1);
			check({12'h000, squelch_o}, 16'(i));
		end
		d = pdb_word_t'($urandom());
		bus(1'b1, 1'b0, 5'h1C, d);
		rd(5'h1C, d & 16'h07FF);
		d[15] = 1'b0;
		bus(1'b1, 1'b0, 5'h1B, d);
		rd(5'h1B, {8'h00, d[7:0]});
		idle(1);
		errs(5);
		bus(1'b1, 1'b0, 5'h1B, {8'h80, d[7:0]});
		rd(5'h1B, {8'h05, d[7:0]});
		idle(1);
		errs(300);
		bus(1'b1, 1'b0, 5'h1B, {8'h80, d[7:0]});
		rd(5'h1B, {8'hFF, d[7:0]});
		bus(1'b1, 1'b0, 5'h1B, {8'h80, d[7:0]});
		rd(5'h1B, {8'h00, d[7:0]});
		idle(1);
		// Wrapping counter mode: 257 errors leave one
		err_cnt_mode_i <= 1'b1;
		errs(257);
		bus(1'b1, 1'b0, 5'h1B, {8'h80, d[7:0]});
		rd(5'h1B, {8'h01, d[7:0]});
		err_cnt_mode_i <= 1'b0;
		idle(1);
		pol_inv_i <= 1'b1;
		idle(8);
		check({15'h0000, irq_o}, 16'h0000);
		bus(1'b1, 1'b0, 5'h1F, 16'h0001);
		gen_status_rd_i <= 1'b1;
		idle(1);
		gen_status_rd_i <= 1'b0;
		idle(3);
		check({14'h0000, gen_status_pol_o, irq_o}, 16'h0003);
		rd(5'h1A, c | 16'h0010);
		rd(5'h1A, c);
		rd(5'h1D, 16'h0009);
		bus(1'b1, 1'b0, 5'h1D, 16'h0001);
		idle(3);
		check({14'h0000, gen_status_pol_o, irq_o}, 16'h0000);
		rd(5'h1D, 16'h0008);
		bus(1'b1, 1'b0, 5'h1E, 16'hC000);
		idle(2);
		check({14'h0000, cd_start_o, rescal_o}, 16'h0003);
		cd_done_i <= 1'b1;
		cd_fail_i <= 1'b1;
		idle(1);
		cd_done_i <= 1'b0;
		cd_fail_i <= 1'b0;
		idle(2);
		rd(5'h1E, 16'h4003);
		idle(3);
		// Passing measurement, calibration bit written low
		bus(1'b1, 1'b0, 5'h1E, 16'h8000);
		idle(1);
		cd_done_i <= 1'b1;
		idle(1);
		cd_done_i <= 1'b0;
		idle(2);
		rd(5'h1E, 16'h0002);
		idle(3);
		// Mid-run reset with the polarity pin back at its idle level
		pol_inv_i <= 1'b0;
		idle(6);
		sys_rst_i <= 1'b1;
		idle(2);
		sys_rst_i <= 1'b0;
		rd(5'h1A, 16'h0000);
		rd(5'h1B, 16'h007D);
		rd(5'h1C, 16'h05EE);
		rd(5'h1E, 16'h0000);
		rd(5'h1D, 16'h0000);
		idle(3);
		check(16'(exp_q.size()), 16'h0000);
		conclude();
	end
endmodule : pdb_regs_tb_top
`default_nettype wire
